//--- design/ecd_channel.sv
// one timer channel: external event counter and frequency divider
// Operation
// - interrupt after reload plus one valid edges
// - count register counts down in event mode
// - start sets enable, loads count from reload in event mode
// - decrement per edge; at zero reload, interrupt
// - reload writable anytime, used next period
// - start trigger bit always reads zero
// - stop clears enable, holds count, self-clears
// - unit disabled: clock stopped, writes ignored
// - unit disable resets channel, output, pin mode
// - clock select codes map prescaled clocks
// - mode bit is master, split or zero
// - divider exists only on channels zero, three
// - divider loads reload on first valid edge
// - start interrupt bit gates first toggle, interrupt
// - divider toggles output and reloads at zero
// - output period is twice reload plus one
// - output period jitters one operation clock
// - eight channels numbered zero to seven
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
module ecd_channel
  import ecd_pkg::*;
#(
  parameter int CHAN_NUM = 0
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // timer pins
  input  wire logic              timer_input_pin_i,
  output logic                   timer_output_pin_o,
  output logic                   timer_pin_mode_o,
  // events and status
  output logic                   channel_interrupt_o,
  output logic                   enable_status_o
);
  // the channel number must name one of the eight channels
  localparam logic CHAN_OK = (CHAN_NUM >= 0) && (CHAN_NUM < NUM_CHAN);
  localparam logic HAS_DIV = CHAN_OK && chan_has_divider(CHAN_NUM);
  localparam logic HAS_CK23 = chan_has_split(CHAN_NUM);
  localparam logic HAS_MS = chan_has_split(CHAN_NUM) || chan_has_master(CHAN_NUM);

  logic                      unit_en;
  logic [NUM_CK*PSC_W-1:0]   prescale_sel;
  logic [1:0]                ck_sel;
  logic                      ms_bit;
  logic [1:0]                edge_sel;
  logic                      div_mode;
  logic                      start_irq;
  logic [DATA_W-1:0]         reload_register;
  logic [DATA_W-1:0]         count_register;
  logic                      out_val;
  logic                      out_en;
  logic                      out_mode;
  logic                      out_lvl;
  logic                      nf_en;
  ecd_state_t                state;
  ecd_state_t                next_state;
  logic                      wr_ok;
  logic                      start_req;
  logic                      stop_req;
  logic                      op_tick;
  logic                      edge_pulse;
  logic                      cnt_zero;
  logic                      do_event;
  logic                      toggle_req;
  logic [DATA_W-1:0]         next_count;
  logic [DATA_W-1:0]         next_rdata;
  logic [DATA_W-1:0]         mode_word;
  logic [DATA_W-1:0]         out_word;

  // writes other than to the unit control only land while the unit runs
  assign wr_ok     = wr_i && unit_en;
  assign start_req = wr_ok && (addr_i == ADDR_TRIGGER) && wdata_i[START_BIT];
  assign stop_req  = wr_ok && (addr_i == ADDR_TRIGGER) && wdata_i[STOP_BIT];
  assign cnt_zero  = count_register == CNT_ZERO;

  // unit enable is always writable
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      unit_en <= 1'b0;
    end else if (wr_i && (addr_i == ADDR_UNIT_CTRL)) begin
      unit_en <= wdata_i[UNIT_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prescale_sel <= '0;
    end else if (!unit_en) begin
      prescale_sel <= '0;
    end else if (wr_ok && (addr_i == ADDR_PRESCALE)) begin
      prescale_sel <= wdata_i[NUM_CK*PSC_W-1:0];
    end
  end

  // mode register; fields fixed where the channel lacks the feature
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ck_sel    <= CK_SEL_0;
      ms_bit    <= 1'b0;
      edge_sel  <= EDGE_FALL;
      div_mode  <= 1'b0;
      start_irq <= 1'b0;
    end else if (!unit_en) begin
      ck_sel    <= CK_SEL_0;
      ms_bit    <= 1'b0;
      edge_sel  <= EDGE_FALL;
      div_mode  <= 1'b0;
      start_irq <= 1'b0;
    end else if (wr_ok && (addr_i == ADDR_MODE)) begin
      ck_sel[1] <= wdata_i[CKS_HI];
      ck_sel[0] <= wdata_i[CKS_LO] && HAS_CK23;
      ms_bit    <= wdata_i[MS_BIT] && HAS_MS;
      edge_sel  <= wdata_i[EDGE_HI:EDGE_LO];
      div_mode  <= wdata_i[DIV_MODE_BIT] && HAS_DIV;
      start_irq <= wdata_i[START_IRQ_BIT];
    end
  end

  // reload value is picked up only at the next load
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reload_register <= RST_WORD;
    end else if (!unit_en) begin
      reload_register <= RST_WORD;
    end else if (wr_ok && (addr_i == ADDR_RELOAD)) begin
      reload_register <= wdata_i;
    end
  end

  // output control bits; timer toggles win over a same-cycle software write
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_en   <= 1'b0;
      out_mode <= 1'b0;
      out_lvl  <= 1'b0;
      nf_en    <= 1'b0;
    end else if (!unit_en) begin
      out_en   <= 1'b0;
      out_mode <= 1'b0;
      out_lvl  <= 1'b0;
      nf_en    <= 1'b0;
    end else if (wr_ok && (addr_i == ADDR_OUTPUT)) begin
      out_en   <= wdata_i[OUT_EN_BIT];
      out_mode <= wdata_i[OUT_MODE_BIT];
      out_lvl  <= wdata_i[OUT_LVL_BIT];
      nf_en    <= wdata_i[NF_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_val <= 1'b0;
    end else if (!unit_en) begin
      out_val <= 1'b0;
    end else if (toggle_req && out_en) begin
      out_val <= !out_val;
    end else if (wr_ok && (addr_i == ADDR_OUTPUT)) begin
      out_val <= wdata_i[OUT_VAL_BIT];
    end
  end

  ecd_prescaler #(
    .CNT_W (PSC_CNT_W)
  ) u_prescaler (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .run_i     (unit_en),
    .div_sel_i (prescale_sel),
    .ck_sel_i  (ck_sel),
    .op_tick_o (op_tick)
  );

  ecd_input_cond u_input_cond (
    .sys_clk_i         (sys_clk_i),
    .reset_i           (reset_i),
    .clear_i           (state == ST_IDLE),
    .op_tick_i         (op_tick),
    .filter_en_i       (nf_en),
    .edge_sel_i        (edge_sel),
    .timer_input_pin_i (timer_input_pin_i),
    .edge_pulse_o      (edge_pulse)
  );

  // channel sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        // stop wins over a start written in the same word
        if (start_req && !stop_req) begin
          next_state = div_mode ? ST_WAIT : ST_RUN;
        end
      end
      ST_WAIT: begin
        if (stop_req) begin
          next_state = ST_IDLE;
        end else if (start_req) begin
          next_state = ST_WAIT;
        end else if (edge_pulse) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stop_req) begin
          next_state = ST_IDLE;
        end else if (start_req) begin
          next_state = div_mode ? ST_WAIT : ST_RUN;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else if (!unit_en) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // counting: reload on start in event mode, first divider edge, or on zero
  always_comb begin
    next_count = count_register;
    do_event   = 1'b0;
    toggle_req = 1'b0;
    if (stop_req) begin
      next_count = count_register;
    end else if (start_req && !div_mode) begin
      next_count = reload_register;
    end else if (start_req) begin
      next_count = count_register;
    end else if ((state == ST_WAIT) && edge_pulse) begin
      next_count = reload_register;
      do_event   = start_irq;
      toggle_req = start_irq;
    end else if ((state == ST_RUN) && edge_pulse) begin
      if (cnt_zero) begin
        next_count = reload_register;
        do_event   = 1'b1;
        toggle_req = div_mode;
      end else begin
        next_count = count_register - CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_register <= RST_WORD;
    end else if (!unit_en) begin
      count_register <= RST_WORD;
    end else begin
      count_register <= next_count;
    end
  end

  // event pulse; divider period is 2*(reload+1) edges on one edge
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      channel_interrupt_o <= 1'b0;
    end else begin
      channel_interrupt_o <= unit_en && do_event;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      enable_status_o <= 1'b0;
    end else begin
      enable_status_o <= unit_en && (next_state != ST_IDLE);
    end
  end

  // pin: the port owns it while the unit is off
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      timer_output_pin_o <= 1'b0;
      timer_pin_mode_o   <= 1'b0;
    end else begin
      timer_output_pin_o <= unit_en && out_val;
      timer_pin_mode_o   <= unit_en;
    end
  end

  // register readback
  always_comb begin
    mode_word = RST_WORD;
    mode_word[CKS_HI]        = ck_sel[1];
    mode_word[CKS_LO]        = ck_sel[0];
    mode_word[MS_BIT]        = ms_bit;
    mode_word[EDGE_HI:EDGE_LO] = edge_sel;
    mode_word[DIV_MODE_BIT]  = div_mode;
    mode_word[START_IRQ_BIT] = start_irq;
    out_word = RST_WORD;
    out_word[OUT_VAL_BIT]  = out_val;
    out_word[OUT_EN_BIT]   = out_en;
    out_word[OUT_MODE_BIT] = out_mode;
    out_word[OUT_LVL_BIT]  = out_lvl;
    out_word[NF_EN_BIT]    = nf_en;
  end

  always_comb begin
    next_rdata = RST_WORD;
    if (addr_i == ADDR_UNIT_CTRL) begin
      next_rdata[UNIT_EN_BIT] = unit_en;
    end else if (addr_i == ADDR_PRESCALE) begin
      next_rdata[NUM_CK*PSC_W-1:0] = prescale_sel;
    end else if (addr_i == ADDR_MODE) begin
      next_rdata = mode_word;
    end else if (addr_i == ADDR_RELOAD) begin
      next_rdata = reload_register;
    end else if (addr_i == ADDR_COUNT) begin
      next_rdata = count_register;
    end else if (addr_i == ADDR_TRIGGER) begin
      next_rdata = RST_WORD;
    end else if (addr_i == ADDR_STATUS) begin
      next_rdata[ENST_BIT] = state != ST_IDLE;
      next_rdata[WAIT_BIT] = state == ST_WAIT;
    end else if (addr_i == ADDR_OUTPUT) begin
      next_rdata = out_word;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= RST_WORD;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= RST_WORD;
    end
  end
endmodule

//--- design/ecd_pkg.sv
// shared constants and types of the event counter / divider channel
package ecd_pkg;
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 4;
  localparam int NUM_CHAN  = 8;
  localparam int PSC_W     = 4;
  localparam int NUM_CK    = 4;
  localparam int PSC_CNT_W = 16;

  // register indices
  localparam logic [3:0] ADDR_UNIT_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PRESCALE  = 4'h1;
  localparam logic [3:0] ADDR_MODE      = 4'h2;
  localparam logic [3:0] ADDR_RELOAD    = 4'h3;
  localparam logic [3:0] ADDR_COUNT     = 4'h4;
  localparam logic [3:0] ADDR_TRIGGER   = 4'h5;
  localparam logic [3:0] ADDR_STATUS    = 4'h6;
  localparam logic [3:0] ADDR_OUTPUT    = 4'h7;

  // unit control / trigger / status fields
  localparam int UNIT_EN_BIT = 0;
  localparam int START_BIT   = 0;
  localparam int STOP_BIT    = 1;
  localparam int ENST_BIT    = 0;
  localparam int WAIT_BIT    = 1;

  // mode register fields
  localparam int CKS_HI       = 15;
  localparam int CKS_LO       = 14;
  localparam int MS_BIT       = 11;
  localparam int EDGE_HI      = 7;
  localparam int EDGE_LO      = 6;
  localparam int DIV_MODE_BIT = 1;
  localparam int START_IRQ_BIT = 0;

  // output control fields
  localparam int OUT_VAL_BIT  = 0;
  localparam int OUT_EN_BIT   = 1;
  localparam int OUT_MODE_BIT = 2;
  localparam int OUT_LVL_BIT  = 3;
  localparam int NF_EN_BIT    = 4;

  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [1:0] CK_SEL_0 = 2'h0;
  localparam logic [1:0] CK_SEL_1 = 2'h2;
  localparam logic [1:0] CK_SEL_2 = 2'h1;
  localparam logic [1:0] CK_SEL_3 = 2'h3;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2
  } ecd_edge_t;

  // gray coded along idle -> wait -> run
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_RUN  = 2'h3
  } ecd_state_t;

  function automatic logic chan_has_split(input int ch);
    return (ch == 1) || (ch == 3);
  endfunction

  function automatic logic chan_has_master(input int ch);
    return (ch == 2) || (ch == 4) || (ch == 6);
  endfunction

  function automatic logic chan_has_divider(input int ch);
    return (ch == 0) || (ch == 3);
  endfunction
endpackage

//--- design/ecd_prescaler.sv
// four prescaled clock ticks and the selected operation clock tick
`timescale 1ns/1ns
module ecd_prescaler
  import ecd_pkg::*;
#(
  parameter int CNT_W = PSC_CNT_W
) (
  // clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    reset_i,
  // control
  input  wire logic                    run_i,
  input  wire logic [NUM_CK*PSC_W-1:0] div_sel_i,
  input  wire logic [1:0]              ck_sel_i,
  // tick
  output logic                         op_tick_o
);
  logic [CNT_W-1:0]  cnt;
  logic [NUM_CK-1:0] ck_tick;

  // each tick fires when the low div_sel bits of the counter are all ones
  function automatic logic tick_of(input logic [CNT_W-1:0] c, input logic [PSC_W-1:0] s);
    logic [CNT_W-1:0] mask;
    mask = CNT_W'((32'h1 << s) - 32'h1);
    return (c & mask) == mask;
  endfunction

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
    end else if (!run_i) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CK; i++) begin
      ck_tick[i] = run_i && tick_of(cnt, div_sel_i[i*PSC_W +: PSC_W]);
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_tick_o <= 1'b0;
    end else begin
      case (ck_sel_i)
        CK_SEL_0: op_tick_o <= ck_tick[0];
        CK_SEL_1: op_tick_o <= ck_tick[1];
        CK_SEL_2: op_tick_o <= ck_tick[2];
        default:  op_tick_o <= ck_tick[3];
      endcase
    end
  end
endmodule

//--- design/ecd_input_cond.sv
// timer input synchroniser, noise filter and valid edge detector
`timescale 1ns/1ns
module ecd_input_cond
  import ecd_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // control
  input  wire logic       clear_i,
  input  wire logic       op_tick_i,
  input  wire logic       filter_en_i,
  input  wire logic [1:0] edge_sel_i,
  // pin and event
  input  wire logic       timer_input_pin_i,
  output logic            edge_pulse_o
);
  logic sync1;
  logic sync2;
  logic samp;
  logic filt;
  logic filt_q;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= timer_input_pin_i;
      sync2 <= sync1;
    end
  end

  // sampling on the operation clock costs up to one tick of skew
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      samp <= 1'b0;
      filt <= 1'b0;
    end else if (clear_i) begin
      samp <= sync2;
      filt <= sync2;
    end else if (op_tick_i) begin
      samp <= sync2;
      if (!filter_en_i || (sync2 == samp)) begin
        filt <= sync2;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      filt_q       <= 1'b0;
      edge_pulse_o <= 1'b0;
    end else begin
      filt_q <= filt;
      if (clear_i) begin
        edge_pulse_o <= 1'b0;
      end else begin
        case (edge_sel_i)
          EDGE_RISE: edge_pulse_o <= filt && !filt_q;
          EDGE_BOTH: edge_pulse_o <= filt != filt_q;
          default:   edge_pulse_o <= !filt && filt_q;
        endcase
      end
    end
  end
endmodule

//--- tb/ecd_channel_properties.sv
// port assertions of the event counter / divider channel
`timescale 1ns/1ns
module ecd_channel_check
  import ecd_pkg::*;
#(
  parameter int CHAN_NUM = 0
) (
  // clock and reset
  input wire logic              sys_clk_i,
  input wire logic              reset_i,
  // register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  // pins and events
  input wire logic              timer_input_pin_i,
  input wire logic              timer_output_pin_o,
  input wire logic              timer_pin_mode_o,
  input wire logic              channel_interrupt_o,
  input wire logic              enable_status_o
);
  logic unit_on;
  logic trig_wr;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // unit enable as software last wrote it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      unit_on <= 1'b0;
    end else if (wr_i && addr_i == ADDR_UNIT_CTRL) begin
      unit_on <= wdata_i[UNIT_EN_BIT];
    end
  end
  assign trig_wr = wr_i && unit_on && (addr_i == ADDR_TRIGGER);

  a_rdata_idle: assert property (!rd_i |=> rdata_o == RST_WORD)
    else $error("read data not zero outside read cycle");
  a_trig_reads_zero: assert property (
    rd_i && addr_i == ADDR_TRIGGER |=> rdata_o == RST_WORD)
    else $error("trigger register read not zero");
  a_start_enables: assert property (
    trig_wr && wdata_i[START_BIT] && !wdata_i[STOP_BIT] |=> enable_status_o)
    else $error("start did not set enable status");
  a_stop_disables: assert property (
    trig_wr && wdata_i[STOP_BIT] |=> !enable_status_o)
    else $error("stop did not clear enable status");
  a_unit_off: assert property (
    !unit_on |-> ##1 (!enable_status_o && !timer_output_pin_o && !timer_pin_mode_o))
    else $error("unit off but channel outputs active");
  a_irq_pulse: assert property (channel_interrupt_o |=> !channel_interrupt_o)
    else $error("interrupt longer than one cycle");
  a_irq_needs_run: assert property (channel_interrupt_o |-> $past(enable_status_o))
    else $error("interrupt while channel stopped");
  a_en_cause: assert property ($changed(enable_status_o) |-> $past(wr_i))
    else $error("enable status changed without a write");
  a_toggle_cause: assert property (
    $changed(timer_output_pin_o) && !$past(wr_i, 2) |-> $past(channel_interrupt_o))
    else $error("output toggled without interrupt");
endmodule

bind ecd_channel ecd_channel_check #(.CHAN_NUM(CHAN_NUM)) i_chk (
  .sys_clk_i          (sys_clk_i),
  .reset_i            (reset_i),
  .addr_i             (addr_i),
  .wdata_i            (wdata_i),
  .wr_i               (wr_i),
  .rd_i               (rd_i),
  .rdata_o            (rdata_o),
  .timer_input_pin_i  (timer_input_pin_i),
  .timer_output_pin_o (timer_output_pin_o),
  .timer_pin_mode_o   (timer_pin_mode_o),
  .channel_interrupt_o(channel_interrupt_o),
  .enable_status_o    (enable_status_o)
);

//--- tb/ecd_edge_src.sv
// external edge source driving the timer input pin
`timescale 1ns/1ns
module ecd_edge_src (
  // clock
  input  wire logic sys_clk_i,
  // timer input pin
  output logic      pin_o
);
  initial pin_o = 1'b0;
  // each level lasts half clocks; small half is prompt, large is slow
  task automatic pulse(input int n, input int half);
    for (int k = 0; k < n; k++) begin
      repeat (half) @(posedge sys_clk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge sys_clk_i);
      pin_o <= 1'b0;
    end
  endtask
endmodule

//--- tb/tb.sv
// testbench of the event counter / divider channel
`timescale 1ns/1ns
module tb;
  import ecd_pkg::*;
  logic              sys_clk_i;
  logic              reset_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i;
  logic              wr_i;
  logic              rd_i;
  logic [DATA_W-1:0] rdata_o;
  logic              pin;
  logic              out_pin;
  logic              pin_mode;
  logic              irq;
  logic              en_st;
  logic              out_q;
  int                err_total;
  int                tests_run;
  int                ints;
  int                tgl;

  ecd_channel #(.CHAN_NUM(3)) i_dut (
    .sys_clk_i          (sys_clk_i),
    .reset_i            (reset_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .rdata_o            (rdata_o),
    .timer_input_pin_i  (pin),
    .timer_output_pin_o (out_pin),
    .timer_pin_mode_o   (pin_mode),
    .channel_interrupt_o(irq),
    .enable_status_o    (en_st)
  );
  ecd_edge_src i_src (.sys_clk_i(sys_clk_i), .pin_o(pin));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // interrupt pulses and output toggles seen so far
  always @(posedge sys_clk_i) begin
    if (irq === 1'b1) ints <= ints + 1;
    if (out_pin !== out_q) tgl <= tgl + 1;
    out_q <= out_pin;
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    chk(rdata_o, exp);
  endtask

  // rising edges, then time for sync, filter and count update
  task automatic edges(input int n);
    i_src.pulse(n, 4);
    repeat (8) @(posedge sys_clk_i);
  endtask

  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    give_verdict();
  end

  initial begin
    int i0;
    int t0;
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    wr(ADDR_RELOAD, 16'h00AA);
    wr(ADDR_UNIT_CTRL, 16'h0001);
    rd(ADDR_RELOAD, 16'h0000);
    rd(4'hF, 16'h0000);
    chk({15'h0000, pin_mode}, 16'h0001);
    wr(ADDR_PRESCALE, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MODE, 16'(c << 14) | 16'h0840);
      rd(ADDR_MODE, 16'(c << 14) | 16'h0840);
    end
    // event counter, rising edges, filter on, output disabled
    wr(ADDR_MODE, 16'h0040);
    wr(ADDR_OUTPUT, 16'h0010);
    wr(ADDR_RELOAD, 16'h0003);
    wr(ADDR_TRIGGER, 16'h0001);
    rd(ADDR_COUNT, 16'h0003);
    rd(ADDR_TRIGGER, 16'h0000);
    chk({15'h0000, en_st}, 16'h0001);
    i0 = ints;
    edges(1);
    rd(ADDR_COUNT, 16'h0002);
    edges(3);
    rd(ADDR_COUNT, 16'h0003);
    chk(16'(ints - i0), 16'h0001);
    wr(ADDR_RELOAD, 16'h0005);
    edges(3);
    rd(ADDR_COUNT, 16'h0000);
    edges(1);
    rd(ADDR_COUNT, 16'h0005);
    chk(16'(ints - i0), 16'h0002);
    wr(ADDR_TRIGGER, 16'h0002);
    edges(2);
    rd(ADDR_COUNT, 16'h0005);
    rd(ADDR_TRIGGER, 16'h0000);
    chk({15'h0000, en_st}, 16'h0000);
    // divider, output enabled, start interrupt bit set then clear
    wr(ADDR_OUTPUT, 16'h0002);
    wr(ADDR_RELOAD, 16'h0001);
    for (int b = 1; b >= 0; b--) begin
      wr(ADDR_MODE, 16'h0042 | 16'(b));
      wr(ADDR_TRIGGER, 16'h0001);
      rd(ADDR_COUNT, (b == 1) ? 16'h0005 : 16'h0001);
      rd(ADDR_STATUS, 16'h0003);
      i0 = ints;
      t0 = tgl;
      edges(1);
      rd(ADDR_COUNT, 16'h0001);
      chk(16'(ints - i0), 16'(b));
      chk(16'(tgl - t0), 16'(b));
      edges(4);
      chk(16'(tgl - t0), 16'(b + 2));
      wr(ADDR_TRIGGER, 16'h0002);
    end
    // unit off clears pin, pin mode and registers
    wr(ADDR_UNIT_CTRL, 16'h0000);
    repeat (2) @(posedge sys_clk_i);
    chk({14'h0000, out_pin, pin_mode}, 16'h0000);
    wr(ADDR_UNIT_CTRL, 16'h0001);
    rd(ADDR_RELOAD, 16'h0000);
    rd(ADDR_OUTPUT, 16'h0000);
    rd(ADDR_COUNT, 16'h0000);
    give_verdict();
  end
endmodule
